// ---- e1tx_pkg.sv ----
// shared constants and types of the e1 transmit digital input block
package e1tx_pkg;

  // rates and hold thresholds
  localparam int CLK_SYS_HZ      = 25_000_000;  // master clock rate
  localparam int E1_RATE_HZ      = 2_048_000;   // 2.048 MHz transmit clock rate
  localparam int ONES_DIV        = CLK_SYS_HZ / E1_RATE_HZ;  // sys cycles per all-ones bit
  localparam int CLK_HOLD_CYCLES = 16;          // master cycles of a stuck transmit clock
  localparam int NEG_HOLD_CYCLES = 16;          // transmit clock cycles of negative pin high
  localparam int PIPE_DEPTH      = 4;           // hdb3 look-ahead depth

  // reset values and the zero run limit
  localparam logic [1:0] ZERO_CNT_RST = 2'h0;
  localparam logic [1:0] ZERO_CNT_MAX = 2'h3;
  localparam logic [3:0] DIV_RST      = 4'h0;
  localparam logic [4:0] HOLD_RST     = 5'h00;

  // symbol codes inside the look-ahead pipeline
  typedef enum logic [1:0] {
    CODE_ZERO = 2'h0,
    CODE_ONE  = 2'h1,
    CODE_B    = 2'h2,
    CODE_V    = 2'h3
  } e1tx_code_t;

  // transmitter operating state
  typedef enum logic [1:0] {
    ST_NORMAL   = 2'h0,
    ST_ALL_ONES = 2'h1,
    ST_PDOWN    = 2'h2
  } e1tx_state_t;

  // one line symbol: positive mark, negative mark, or neither
  typedef struct packed {
    logic pos;
    logic neg;
  } e1tx_sym_t;

  // strap configuration
  typedef struct packed {
    logic dual;
    logic hdb3;
    logic bpv_en;
  } e1tx_cfg_t;

  localparam e1tx_sym_t SYM_SPACE = 2'h0;
  localparam e1tx_cfg_t CFG_RST   = 3'h0;

endpackage : e1tx_pkg

// ---- e1tx_channel.sv ----
// one e1 transmit channel: sampling, line coding, clock supervision, driver enable
//
// Operation
// - transmit data is sampled on each falling edge of the 2.048 MHz channel clock
// - single rail nrz data is encoded as ami or hdb3 before reaching the line
// - violation input rising edge gives the next one the previous pulse polarity
// - dual rail positive and negative inputs are both sampled on falling clock edges
// - dual rail: both inputs equal gives space; negative only gives a negative pulse
// - negative input held high over a sustained run reconfigures the rail mode
// - channel clock high over sixteen master cycles enters transmit all ones
// - in transmit all ones the generator runs from the master clock
// - channel clock held low powers the channel down with drivers off
// - drivers are off when the global enable is low or host disable is set
module e1tx_channel
  import e1tx_pkg::*;
#(
  parameter int CLK_HOLD = CLK_HOLD_CYCLES,  // master cycles before a stuck clock acts
  parameter int NEG_HOLD = NEG_HOLD_CYCLES   // link cycles of negative pin high
)
(
  input  wire logic      clk_sys,           // master clock, 25 MHz
  input  wire logic      reset,             // synchronous, active high
  input  wire logic      tx_channel_clock,  // channel transmit clock from the framer
  input  wire logic      tx_nrz_data,       // nrz data, or positive pulse in dual rail
  input  wire logic      violation_insert_in, // violation insert, or negative pulse
  input  wire e1tx_cfg_t cfg_strap,         // rail mode, hdb3 and violation enable
  input  wire logic      global_oe,         // global driver enable pin, high enables
  input  wire logic      host_oe_off,       // host driver disable bit, high disables
  output logic           line_pos,          // positive mark to the line driver
  output logic           line_neg,          // negative mark to the line driver
  output logic           line_drive_en,     // driver output enable, low is high-z
  output e1tx_state_t    tx_state           // normal, all ones or power down
);

  localparam logic [4:0] HOLD_CNT = 5'(CLK_HOLD);
  localparam logic [4:0] NEG_CNT  = 5'(NEG_HOLD - 1);
  localparam logic [3:0] DIV_LAST = 4'(ONES_DIV - 1);

  // refuse settings the counters cannot hold; below eight a running clock looks stuck
  if (CLK_HOLD < 8 || CLK_HOLD > 30 || NEG_HOLD < 1 || NEG_HOLD > 31)
  begin : g_bad_param
    $error("hold counts out of range");
  end

  // dual rail pins share the single rail pins
  logic tx_positive_pulse_in;
  logic tx_negative_pulse_in;
  assign tx_positive_pulse_in = tx_nrz_data;
  assign tx_negative_pulse_in = violation_insert_in;

  // link domain state
  logic        lrst_meta;
  logic        lrst_reg;
  e1tx_cfg_t   cfg_meta;
  e1tx_cfg_t   cfg_reg;
  logic [4:0]  neg_run_reg;
  logic        rail_override_reg;
  logic        viol_prev_reg;
  logic        viol_pend_reg;
  e1tx_code_t  code_reg [PIPE_DEPTH];
  logic [1:0]  zero_cnt_reg;
  logic        parity_reg;
  logic        last_pol_reg;
  e1tx_sym_t   sym_reg;
  logic        tog_reg;
  logic        dual_eff;
  logic        sub_now;
  e1tx_code_t  in_code;

  // system domain state
  logic        tclk_meta;
  logic        tclk_sync;
  logic        tclk_prev;
  logic        oe_meta;
  logic        oe_sync;
  logic        tog_meta;
  logic        tog_sync;
  logic        tog_prev;
  e1tx_sym_t   sym_cap_reg;
  logic [4:0]  hold_cnt_reg;
  e1tx_state_t state_reg;
  logic [3:0]  div_reg;
  logic        ones_pol_reg;
  logic        ones_tick;

  // reset and straps into the link domain; the clock may stop, so reset
  // only reaches this side once the framer clocks again
  always_ff @(negedge tx_channel_clock)
  begin
    lrst_meta <= reset;
    lrst_reg  <= lrst_meta;
    cfg_meta  <= cfg_strap;
    cfg_reg   <= cfg_meta;
  end

  // sticky rail override after a long run of negative pin high
  always_ff @(negedge tx_channel_clock)
  begin
    if (lrst_reg)
    begin
      neg_run_reg       <= HOLD_RST;
      rail_override_reg <= 1'b0;
    end
    else if (cfg_reg.dual && tx_negative_pulse_in)
    begin
      if (neg_run_reg != NEG_CNT)
        neg_run_reg <= neg_run_reg + 5'h01;
      else
        rail_override_reg <= 1'b1;
    end
    else
      neg_run_reg <= HOLD_RST;
  end

  // override drops the channel to single rail with violation insert
  assign dual_eff = cfg_reg.dual && !rail_override_reg;

  // violation request: a rise arms the next one; a rise wins over consumption
  always_ff @(negedge tx_channel_clock)
  begin
    if (lrst_reg)
    begin
      viol_prev_reg <= 1'b0;
      viol_pend_reg <= 1'b0;
    end
    else
    begin
      viol_prev_reg <= violation_insert_in;
      if (violation_insert_in && !viol_prev_reg)
        viol_pend_reg <= 1'b1;
      else if (tx_nrz_data)
        viol_pend_reg <= 1'b0;
    end
  end

  // classify the sampled bit
  always_comb
  begin
    in_code = CODE_ZERO;
    if (tx_nrz_data)
    begin
      if ((cfg_reg.bpv_en || rail_override_reg) && !dual_eff && viol_pend_reg)
        in_code = CODE_V;
      else
        in_code = CODE_ONE;
    end
  end

  // fourth zero in a row under hdb3 forces a substitution
  assign sub_now = cfg_reg.hdb3 && !dual_eff && (in_code == CODE_ZERO)
                   && (zero_cnt_reg == ZERO_CNT_MAX);

  // look-ahead pipeline; ami runs through it too so latency never depends on code
  always_ff @(negedge tx_channel_clock)
  begin
    if (lrst_reg)
    begin
      for (int i = 0; i < PIPE_DEPTH; i++)
        code_reg[i] <= CODE_ZERO;
      zero_cnt_reg <= ZERO_CNT_RST;
      parity_reg   <= 1'b0;
    end
    else
    begin
      code_reg[0] <= in_code;
      for (int i = 1; i < PIPE_DEPTH; i++)
        code_reg[i] <= code_reg[i-1];
      if (sub_now)
      begin
        // even pulse count since last violation needs a balancing mark
        code_reg[0] <= CODE_V;
        code_reg[PIPE_DEPTH-1] <= parity_reg ? CODE_ZERO : CODE_B;
        zero_cnt_reg <= ZERO_CNT_RST;
        parity_reg   <= 1'b0;
      end
      else if (in_code == CODE_ZERO)
      begin
        if (zero_cnt_reg != ZERO_CNT_MAX)
          zero_cnt_reg <= zero_cnt_reg + 2'h1;
      end
      else
      begin
        zero_cnt_reg <= ZERO_CNT_RST;
        parity_reg   <= ~parity_reg;
      end
    end
  end

  // polarity assignment and the word handed to the master domain
  always_ff @(negedge tx_channel_clock)
  begin
    if (lrst_reg)
    begin
      sym_reg      <= SYM_SPACE;
      last_pol_reg <= 1'b0;
      tog_reg      <= 1'b0;
    end
    else
    begin
      tog_reg <= ~tog_reg;
      if (dual_eff)
        sym_reg <= '{pos: tx_positive_pulse_in && !tx_negative_pulse_in,
                     neg: tx_negative_pulse_in && !tx_positive_pulse_in};
      else
      begin
        case (code_reg[PIPE_DEPTH-1])
          CODE_ONE, CODE_B:
          begin
            sym_reg      <= '{pos: !last_pol_reg, neg: last_pol_reg};
            last_pol_reg <= ~last_pol_reg;
          end
          CODE_V:
            sym_reg <= '{pos: last_pol_reg, neg: !last_pol_reg};
          default:
            sym_reg <= SYM_SPACE;
        endcase
      end
    end
  end

  // synchronisers for the pins and the handover toggle
  always_ff @(posedge clk_sys)
  begin
    tclk_meta <= tx_channel_clock;
    tclk_sync <= tclk_meta;
    oe_meta   <= global_oe;
    oe_sync   <= oe_meta;
    tog_meta  <= tog_reg;
    tog_sync  <= tog_meta;
  end

  // capture a symbol on each toggle; it stands a whole link period, so the
  // three-cycle crossing reads it settled
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tog_prev    <= 1'b0;
      sym_cap_reg <= SYM_SPACE;
    end
    else
    begin
      tog_prev <= tog_sync;
      if (tog_sync != tog_prev)
        sym_cap_reg <= sym_reg;
    end
  end

  // transmit clock supervision in master cycles
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tclk_prev    <= 1'b0;
      hold_cnt_reg <= HOLD_RST;
      state_reg    <= ST_NORMAL;
    end
    else
    begin
      tclk_prev <= tclk_sync;
      if (tclk_sync != tclk_prev)
      begin
        hold_cnt_reg <= HOLD_RST;
        state_reg    <= ST_NORMAL;
      end
      else if (hold_cnt_reg != HOLD_CNT)
        hold_cnt_reg <= hold_cnt_reg + 5'h01;
      else if (tclk_sync)
        state_reg <= ST_ALL_ONES;
      else
        state_reg <= ST_PDOWN;
    end
  end

  // all ones generator divided down from the master clock
  assign ones_tick = (div_reg == DIV_LAST);
  always_ff @(posedge clk_sys)
  begin
    if (reset || state_reg != ST_ALL_ONES)
    begin
      div_reg      <= DIV_RST;
      ones_pol_reg <= 1'b0;
    end
    else if (ones_tick)
    begin
      div_reg      <= DIV_RST;
      ones_pol_reg <= ~ones_pol_reg;
    end
    else
      div_reg <= div_reg + 4'h1;
  end

  // line outputs; driver enable gathers every disable source
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      line_pos      <= 1'b0;
      line_neg      <= 1'b0;
      line_drive_en <= 1'b0;
      tx_state      <= ST_NORMAL;
    end
    else
    begin
      tx_state      <= state_reg;
      line_drive_en <= oe_sync && !host_oe_off && (state_reg != ST_PDOWN);
      case (state_reg)
        ST_NORMAL:
        begin
          line_pos <= sym_cap_reg.pos;
          line_neg <= sym_cap_reg.neg;
        end
        ST_ALL_ONES:
        begin
          line_pos <= ones_pol_reg;
          line_neg <= !ones_pol_reg;
        end
        default:
        begin
          line_pos <= 1'b0;
          line_neg <= 1'b0;
        end
      endcase
    end
  end

  // checks in the link domain
  sequence s_sub_point;
    cfg_reg.hdb3 && !dual_eff && !tx_nrz_data && zero_cnt_reg == ZERO_CNT_MAX;
  endsequence

  property p_hdb3_sub;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    s_sub_point |=> code_reg[0] == CODE_V;
  endproperty
  a_hdb3_sub: assert property (p_hdb3_sub) else $error("hdb3 violation missing");

  property p_ami_space;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    (!cfg_reg.hdb3 && !dual_eff && !tx_nrz_data) ##1 (!cfg_reg.hdb3 && !dual_eff)[*4]
      |=> sym_reg == SYM_SPACE;
  endproperty
  a_ami_space: assert property (p_ami_space) else $error("ami zero not a space");

  property p_viol_code;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    (viol_pend_reg && tx_nrz_data && cfg_reg.bpv_en && !dual_eff) |=> code_reg[0] == CODE_V;
  endproperty
  a_viol_code: assert property (p_viol_code) else $error("violation not inserted");

  property p_dual_space;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    (dual_eff && tx_positive_pulse_in == tx_negative_pulse_in) |=> sym_reg == SYM_SPACE;
  endproperty
  a_dual_space: assert property (p_dual_space) else $error("dual rail space wrong");

  property p_dual_neg;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    (dual_eff && !tx_positive_pulse_in && tx_negative_pulse_in) |=> sym_reg == 2'h1;
  endproperty
  a_dual_neg: assert property (p_dual_neg) else $error("dual rail negative wrong");

  property p_dual_pos;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    (dual_eff && tx_positive_pulse_in && !tx_negative_pulse_in) |=> sym_reg == 2'h2;
  endproperty
  a_dual_pos: assert property (p_dual_pos) else $error("dual rail positive wrong");

  property p_rail_override;
    @(negedge tx_channel_clock) disable iff (lrst_reg)
    (cfg_reg.dual && tx_negative_pulse_in && neg_run_reg == NEG_CNT) |=> !dual_eff;
  endproperty
  a_rail_override: assert property (p_rail_override) else $error("no rail override");

  // checks in the master domain; entry shows in the state first, the output a cycle later
  sequence s_ones_enter;
    state_reg == ST_ALL_ONES ##1 tx_state == ST_ALL_ONES;
  endsequence

  sequence s_ones_step;
    (state_reg == ST_ALL_ONES && ones_tick) ##1 (state_reg == ST_ALL_ONES);
  endsequence

  property p_ones_entry;
    @(posedge clk_sys) disable iff (reset)
    (tclk_sync && tclk_prev && hold_cnt_reg == HOLD_CNT) |=> s_ones_enter;
  endproperty
  a_ones_entry: assert property (p_ones_entry) else $error("all ones not entered");

  property p_ones_rate;
    @(posedge clk_sys) disable iff (reset)
    s_ones_step |=> line_pos != $past(line_pos) && line_pos != line_neg;
  endproperty
  a_ones_rate: assert property (p_ones_rate) else $error("all ones pulse wrong");

  property p_pdown_off;
    @(posedge clk_sys) disable iff (reset)
    state_reg == ST_PDOWN |=> !line_drive_en && !line_pos && !line_neg;
  endproperty
  a_pdown_off: assert property (p_pdown_off) else $error("power down drives line");

  property p_oe_off;
    @(posedge clk_sys) disable iff (reset)
    (!oe_sync || host_oe_off) |=> !line_drive_en;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driver not disabled");

endmodule : e1tx_channel

// ---- e1tx_framer_model.sv ----
// framer model: transmit clock and two cycling data words for one channel
module e1tx_framer_model
(
  input  wire logic        run,   // clock toggles while high
  input  wire logic        park,  // clock level held while stopped
  input  wire logic [31:0] wpos,  // word for the data pin
  input  wire logic [31:0] wneg,  // word for the violation or negative pin
  output logic             tclk,  // channel transmit clock
  output logic             dpos,  // nrz data or positive pulse
  output logic             dneg   // violation insert or negative pulse
);
  timeunit 1ns;
  timeprecision 100ps;

  int idx = 0;

  // 160 ns period with an odd offset against the system clock
  // stopping parks the level, which is how the host asks for all ones or power down
  initial
  begin
    tclk = 1'b0;
    #13;
    forever
    begin
      #80;
      tclk = run ? ~tclk : park;
    end
  end

  // data moves after the rise so it is steady at the sampling fall
  always @(posedge tclk)
  begin
    idx <= (idx + 1) % 32;
  end

  // both pins come from the same bit index
  assign dpos = wpos[idx];
  assign dneg = wneg[idx];
endmodule : e1tx_framer_model

// ---- e1tx_channel_tb_top.sv ----
// self-checking bench for one e1 transmit channel
module e1tx_channel_tb_top
  import e1tx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam e1tx_cfg_t C_DUAL = 3'h4;
  localparam e1tx_cfg_t C_AMI  = 3'h0;
  localparam e1tx_cfg_t C_HDB  = 3'h2;
  localparam e1tx_cfg_t C_BPV  = 3'h1;

  logic        clk_sys, reset, run, park, global_oe, host_oe_off;
  logic        tclk, dpos, dneg, line_pos, line_neg, line_drive_en;
  logic [31:0] wpos, wneg;
  e1tx_cfg_t   cfg;
  e1tx_state_t tx_state;
  int          n_mismatch = 0;
  int          checks = 0;
  int          rp, rn, hp, hn, mx, both;

  e1tx_framer_model u_framer (.run(run), .park(park), .wpos(wpos), .wneg(wneg),
    .tclk(tclk), .dpos(dpos), .dneg(dneg));

  e1tx_channel #(.CLK_HOLD(16), .NEG_HOLD(16)) uut (.clk_sys(clk_sys), .reset(reset),
    .tx_channel_clock(tclk), .tx_nrz_data(dpos), .violation_insert_in(dneg),
    .cfg_strap(cfg), .global_oe(global_oe), .host_oe_off(host_oe_off),
    .line_pos(line_pos), .line_neg(line_neg), .line_drive_en(line_drive_en),
    .tx_state(tx_state));

  // 25 MHz master clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task chk(input string nm, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk

  task chk_st(input string nm, input e1tx_state_t e);
    checks++;
    if (tx_state !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, tx_state);
    end
  endtask : chk_st

  task chk_en(input string nm, input logic e);
    checks++;
    if (line_drive_en !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, line_drive_en);
    end
  endtask : chk_en

  task wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_n

  // rises and high cycles of each mark, longest high run of either mark; pulses start with no rise credit
  task measure(input int n);
    logic pp, pn;
    int   cp, cn;
    rp = 0;
    rn = 0;
    hp = 0;
    hn = 0;
    mx = 0;
    both = 0;
    pp = 1'b1;
    pn = 1'b1;
    cp = 0;
    cn = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (line_pos === 1'b1)
      begin
        hp++;
        cp++;
        rp += !pp;
      end
      else cp = 0;
      if (line_neg === 1'b1)
      begin
        hn++;
        cn++;
        rn += !pn;
      end
      else cn = 0;
      both += (line_pos === 1'b1 && line_neg === 1'b1);
      mx = (cp > mx) ? cp : mx;
      mx = (cn > mx) ? cn : mx;
      pp = (line_pos === 1'b1);
      pn = (line_neg === 1'b1);
    end
  endtask : measure

  // straps and words change together, then the pipeline is given 25 bits to settle
  task set_traffic(input e1tx_cfg_t c, input logic [31:0] p, input logic [31:0] q);
    @(negedge clk_sys);
    cfg = c;
    wpos = p;
    wneg = q;
    wait_n(100);
  endtask : set_traffic

  task do_reset;
    @(negedge clk_sys);
    reset = 1'b1;
    wait_n(16);
    reset = 1'b0;
  endtask : do_reset

  // dual rail truth table, 64 bits in each window
  task t_dual;
    set_traffic(C_DUAL, 32'hFFFFFFFF, 32'h00000000);
    measure(256);
    chk("dual pos high cycles", 256, 256, hp);
    chk("dual pos neg cycles", 0, 0, hn);
    set_traffic(C_DUAL, 32'h00000000, 32'hAAAAAAAA);
    measure(256);
    chk("dual neg rises", 31, 33, rn);
    chk("dual neg pos cycles", 0, 0, hp);
    set_traffic(C_DUAL, 32'hAAAAAAAA, 32'hAAAAAAAA);
    measure(256);
    chk("dual both set marks", 0, 0, hp + hn);
    set_traffic(C_DUAL, 32'hAAAAAAAA, 32'h55555555);
    measure(256);
    chk("dual mixed pos rises", 31, 33, rp);
    chk("dual mixed neg rises", 31, 33, rn);
  endtask : t_dual

  // ami ones alternate, hdb3 zeros give two pulses per four bits, a violation doubles one pulse
  task t_single;
    set_traffic(C_AMI, 32'hFFFFFFFF, 32'h00000000);
    measure(256);
    chk("ami pos rises", 31, 33, rp);
    chk("ami neg rises", 31, 33, rn);
    chk("ami both marks", 0, 0, both);
    chk("ami longest mark", 3, 5, mx);
    set_traffic(C_AMI, 32'h00000000, 32'h00000000);
    measure(128);
    chk("ami zeros marks", 0, 0, hp + hn);
    set_traffic(C_HDB, 32'h00000000, 32'h00000000);
    measure(256);
    chk("hdb3 pos rises", 14, 18, rp);
    chk("hdb3 neg rises", 14, 18, rn);
    // a one then seven zeros leaves an odd count, so only 000V: one and V share a polarity
    set_traffic(C_HDB, 32'h01010101, 32'h00000000);
    measure(256);
    chk("hdb3 odd pos rises", 7, 9, rp);
    chk("hdb3 odd neg rises", 7, 9, rn);
    set_traffic(C_BPV, 32'hFFFFFFFF, 32'h00000001);
    measure(256);
    chk("violation longest mark", 7, 9, mx);
  endtask : t_single

  // stuck-high clock: all ones from the master clock; stuck-low: power down
  task t_clk;
    run = 1'b0;
    park = 1'b1;
    wait_n(12);
    chk_st("state before hold", ST_NORMAL);
    wait_n(18);
    chk_st("state clock high", ST_ALL_ONES);
    measure(240);
    chk("all ones pos rises", 9, 11, rp);
    chk("all ones neg rises", 9, 11, rn);
    chk_en("all ones enable", 1'b1);
    run = 1'b1;
    wait_n(20);
    chk_st("state clock back", ST_NORMAL);
    run = 1'b0;
    park = 1'b0;
    wait_n(30);
    chk_st("state clock low", ST_PDOWN);
    chk_en("power down enable", 1'b0);
    measure(40);
    chk("power down marks", 0, 0, hp + hn);
    run = 1'b1;
    wait_n(40);
  endtask : t_clk

  // global pin sees three cycles of latency, the host bit one
  task t_oe;
    global_oe = 1'b0;
    wait_n(5);
    chk_en("global off", 1'b0);
    global_oe = 1'b1;
    wait_n(5);
    chk_en("global on", 1'b1);
    host_oe_off = 1'b1;
    wait_n(2);
    chk_en("host off", 1'b0);
    host_oe_off = 1'b0;
    wait_n(2);
    chk_en("host on", 1'b1);
  endtask : t_oe

  // negative pin held high: spaces at first, then single rail ami of the ones
  task t_neg;
    cfg = C_DUAL;
    wpos = 32'hFFFFFFFF;
    wneg = 32'hFFFFFFFF;
    do_reset();
    wait_n(40);
    measure(16);
    chk("early both set marks", 0, 0, hp + hn);
    wait_n(160);
    measure(128);
    chk("rail override neg rises", 14, 18, rn);
  endtask : t_neg

  // main sequence, all inputs defined at time zero
  initial
  begin
    reset = 1'b1;
    run = 1'b1;
    park = 1'b0;
    global_oe = 1'b1;
    host_oe_off = 1'b0;
    cfg = C_AMI;
    wpos = 32'h00000000;
    wneg = 32'h00000000;
    do_reset();
    wait_n(40);
    t_dual();
    t_single();
    t_clk();
    t_oe();
    t_neg();
    close_out();
  end

  // the whole run needs about 0.16 ms
  initial
  begin
    #1_000_000;
    n_mismatch++;
    close_out();
  end
endmodule : e1tx_channel_tb_top
